// ===== design/conv_ctrl_pkg.sv
// shared constants for the six-channel conversion control link
package conv_ctrl_pkg;

  // -------------------------------------------------------------------
  // geometry
  // -------------------------------------------------------------------
  localparam int unsigned PAIRS      = 3;
  localparam int unsigned CW_W       = 32;
  localparam int unsigned DAC_W      = 10;

  // -------------------------------------------------------------------
  // control word layout and reset value
  // -------------------------------------------------------------------
  localparam logic [31:0] CW_RESET   = 32'h0000_03FF;
  localparam int unsigned DAC_LSB    = 0;
  localparam int unsigned CLK_SRC_B  = 11;
  localparam int unsigned REF_FS_B   = 18;
  localparam int unsigned BUSY_POL_B = 20;
  localparam int unsigned SEQ_B      = 21;
  localparam int unsigned REF_EN_B   = 22;
  localparam int unsigned RANGE_LSB  = 23;
  // lowest safe dac code at the 2.5 V full scale
  localparam logic [9:0]  DAC_MIN    = 10'h0CC;

  // -------------------------------------------------------------------
  // timing: 18.5 conversion clock cycles, counted in half cycles
  // -------------------------------------------------------------------
  localparam int unsigned CONV_HALF  = 37;
  localparam logic [5:0]  CONV_HALF_W = 6'(CONV_HALF);
  localparam real         CLK_MHZ    = 250.0;
  localparam real         INT_CONV_MHZ = 20.0;
  // internal conversion clock half period in system cycles (rounded down)
  localparam int unsigned INT_HALF_CYC =
    (CLK_MHZ / INT_CONV_MHZ / 2.0 < 1.0) ? 1 :
    int'($floor(CLK_MHZ / INT_CONV_MHZ / 2.0));
  localparam logic [3:0]  INT_HALF_W = 4'(INT_HALF_CYC);

  typedef enum logic [1:0] {
    PAIR_IDLE = 2'b00,
    PAIR_WAIT = 2'b01,
    PAIR_CONV = 2'b10,
    PAIR_DOWN = 2'b11
  } pair_state_e;

endpackage

// ===== design/conv_device.sv
// device end: control word, trigger routing, clocks, busy and range
`timescale 1ns/1ps
// Operation
// - range is four or two times reference
// - range pin latched on busy falling edge; the code latches it only while the busy polarity bit is clear
// - reference select picks 2.5 V or 3 V
// - internal clock default, external in software mode
// - conversion lasts 18.5 conversion clock cycles
// - external clock may stop between conversions
// - trigger rising edge holds pair inputs
// - software mode: first trigger starts all pairs; the code fans it out only while the sequential bit is clear
// - conversion begins on next conversion clock edge
// - host keeps trigger high while busy
// - early trigger fall powers pair down
// - no retrigger of a converting pair
// - busy rises on trigger, falls when loaded
// - host may read right after busy falls
// - sequential mode: busy inactive one cycle
// - control word bit sets busy polarity
// - ten bit dac code sets reference level
// - software keeps dac code above 0.5 V
// - internal reference powered down by default
// - config pin selects hardware or software mode
// - control word resets to 0x000003FF
module conv_device
  import conv_ctrl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  conv_link_if.device link,
  output logic [2:0] pair_hold,
  output logic [2:0] pair_power_down,
  output logic [2:0] pair_result_load,
  output logic [2:0] pair_range_x4,
  output logic       ref_is_3v,
  output logic       ref_enable,
  output logic [9:0] ref_dac_code,
  output logic       dac_code_low,
  output logic       ext_clock_in_use
);

  logic [31:0] cw_reg, cw_next;
  logic [2:0]  trig_prev_reg;
  logic        external_conversion_clock_prev_reg;
  logic [3:0]  div_reg, div_next;
  logic        busy_reg, busy_next;
  logic        gap_reg, gap_next;
  logic        range_latch_reg, range_latch_next;
  logic [2:0]  range_x4_reg, range_x4_next;
  logic        dac_low_reg, dac_low_next;
  logic        ext_use_reg, ext_use_next;
  logic [2:0]  trig_eff;
  logic [2:0]  trig_rise;
  logic [2:0]  pair_busy;
  logic [2:0]  pair_done;
  logic        sw_mode;
  logic        seq_mode;
  logic        use_ext;
  logic        int_edge;
  logic        conv_edge;
  logic        busy_fall;

  // -------------------------------------------------------------------
  // mode and trigger routing
  // -------------------------------------------------------------------
  assign sw_mode  = link.config_source_pin;
  assign seq_mode = cw_reg[SEQ_B];
  assign use_ext  = sw_mode && cw_reg[CLK_SRC_B];

  // in software mode the first trigger drives every pair unless sequential sampling
  always_comb begin
    if (sw_mode && !seq_mode) begin
      trig_eff = {3{link.pair_sample_trigger[0]}};
    end else begin
      trig_eff = link.pair_sample_trigger;
    end
  end
  assign trig_rise = trig_eff & ~trig_prev_reg;

  // -------------------------------------------------------------------
  // control word, only writable in software mode
  // -------------------------------------------------------------------
  // hardware-mode loads are dropped, so a mode switch keeps settings
  always_comb begin
    cw_next = cw_reg;
    if (sw_mode && link.cw_load) begin
      cw_next = link.cw_data;
    end
  end

  // -------------------------------------------------------------------
  // conversion clock: internal divider or sampled external edges
  // -------------------------------------------------------------------
  // both edges of either clock count, giving half-cycle resolution
  always_comb begin
    div_next = div_reg;
    int_edge = 1'b0;
    if (div_reg == INT_HALF_W - 4'd1) begin
      div_next = 4'd0;
      int_edge = 1'b1;
    end else begin
      div_next = div_reg + 4'd1;
    end
  end
  // the external clock is sampled by clk: each level must last at least
  // one system cycle, which 20 MHz leaves with room to spare
  assign conv_edge = use_ext ?
    (link.external_conversion_clock != external_conversion_clock_prev_reg) : int_edge;

  // -------------------------------------------------------------------
  // pairs
  // -------------------------------------------------------------------
  // pairs share one conversion edge, so pairs started together end together
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    pair_converter u_pair (
      .clk        (clk),
      .reset      (reset),
      .trig_rise  (trig_rise[p]),
      .trig_level (trig_eff[p]),
      .conv_edge  (conv_edge),
      .hold       (pair_hold[p]),
      .busy       (pair_busy[p]),
      .done       (pair_done[p]),
      .power_down (pair_power_down[p])
    );
  end
  assign pair_result_load = pair_done;

  // -------------------------------------------------------------------
  // busy, sequential gap and range latch
  // -------------------------------------------------------------------
  // busy follows any pair still converting; a new start in the same
  // cycle as the last load keeps it high
  always_comb begin
    busy_next = (|pair_busy) || (|trig_rise);
    gap_next  = 1'b0;
    if (seq_mode && busy_reg && !(|pair_busy) && (|trig_rise)) begin
      gap_next = 1'b1;
    end
    busy_fall = busy_reg && !busy_next;
    range_latch_next = range_latch_reg;
    if (busy_fall && !cw_reg[BUSY_POL_B]) begin
      range_latch_next = link.range_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cw_reg          <= CW_RESET;
      trig_prev_reg   <= 3'b000;
      external_conversion_clock_prev_reg   <= 1'b0;
      div_reg         <= 4'd0;
      busy_reg        <= 1'b0;
      gap_reg         <= 1'b0;
      range_latch_reg <= 1'b0;
    end else begin
      cw_reg          <= cw_next;
      trig_prev_reg   <= trig_eff;
      external_conversion_clock_prev_reg   <= link.external_conversion_clock;
      div_reg         <= div_next;
      busy_reg        <= busy_next;
      gap_reg         <= gap_next;
      range_latch_reg <= range_latch_next;
    end
  end

  // sequential mode shows one inactive cycle when pairs chain; the gap
  // is only seen when a new start meets the last load exactly
  assign link.busy_int =
    (busy_reg && !gap_reg) ^ cw_reg[BUSY_POL_B];

  // -------------------------------------------------------------------
  // range and reference settings
  // -------------------------------------------------------------------
  // the range follows the word in software mode and the latched pin
  // otherwise; flags are registered so the pins never glitch while
  // the mode pin and the word change in the same cycle
  always_comb begin
    if (sw_mode) begin
      range_x4_next = cw_reg[RANGE_LSB +: 3];
    end else begin
      range_x4_next = {3{range_latch_reg}};
    end
    dac_low_next = cw_reg[DAC_LSB +: DAC_W] < DAC_MIN;
    ext_use_next = use_ext;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      range_x4_reg <= 3'b000;
      dac_low_reg  <= 1'b0;
      ext_use_reg  <= 1'b0;
    end else begin
      range_x4_reg <= range_x4_next;
      dac_low_reg  <= dac_low_next;
      ext_use_reg  <= ext_use_next;
    end
  end

  assign pair_range_x4    = range_x4_reg;
  assign dac_code_low     = dac_low_reg;
  assign ext_clock_in_use = ext_use_reg;
  assign ref_is_3v        = cw_reg[REF_FS_B];
  assign ref_enable       = cw_reg[REF_EN_B];
  assign ref_dac_code     = cw_reg[DAC_LSB +: DAC_W];

endmodule

// ===== design/conv_host.sv
// host end: configures, triggers pairs, waits for busy to fall
`timescale 1ns/1ps
module conv_host
  import conv_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  conv_link_if.host        link,
  input  wire logic        sw_mode,
  input  wire logic        range_pin_level,
  input  wire logic        cfg_write,
  input  wire logic [31:0] cfg_word,
  input  wire logic [2:0]  start_pairs,
  input  wire logic        ext_clock_level,
  input  wire logic        busy_active_low,
  output logic             cfg_refused,
  output logic             start_refused,
  output logic             results_ready,
  output logic [2:0]       active_pairs
);

  logic [2:0] trig_reg, trig_next;
  logic       ready_reg, ready_next;
  logic       refused_reg, refused_next;
  logic       cfg_ref_reg, cfg_ref_next;
  logic       busy_lvl;
  logic       busy_prev_reg;

  assign busy_lvl = link.busy_int ^ busy_active_low;

  // -------------------------------------------------------------------
  // triggers held for the conversion, released when busy falls
  // -------------------------------------------------------------------
  always_comb begin
    trig_next    = trig_reg;
    ready_next   = 1'b0;
    refused_next = 1'b0;
    cfg_ref_next = 1'b0;
    if (busy_prev_reg && !busy_lvl) begin
      trig_next  = 3'b000;
      ready_next = 1'b1;
    end else if (|(start_pairs & trig_reg)) begin
      refused_next = 1'b1;
    end else begin
      trig_next = trig_reg | start_pairs;
    end
    // low dac codes are refused rather than sent
    if (cfg_write && cfg_word[DAC_LSB +: DAC_W] < DAC_MIN) begin
      cfg_ref_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_reg      <= 3'b000;
      ready_reg     <= 1'b0;
      refused_reg   <= 1'b0;
      cfg_ref_reg   <= 1'b0;
      busy_prev_reg <= 1'b0;
    end else begin
      trig_reg      <= trig_next;
      ready_reg     <= ready_next;
      refused_reg   <= refused_next;
      cfg_ref_reg   <= cfg_ref_next;
      busy_prev_reg <= busy_lvl;
    end
  end

  assign link.pair_sample_trigger       = trig_reg;
  assign link.external_conversion_clock = ext_clock_level;
  assign link.config_source_pin         = sw_mode;
  assign link.range_pin                 = range_pin_level;
  assign link.cw_load                   = cfg_write && !cfg_ref_next;
  assign link.cw_data                   = cfg_word;
  assign cfg_refused   = cfg_ref_reg;
  assign start_refused = refused_reg;
  assign results_ready = ready_reg;
  assign active_pairs  = trig_reg;

endmodule

// ===== design/conv_link_if.sv
// pin-level link between the converter control and its host
`timescale 1ns/1ps
interface conv_link_if;
  logic [2:0]  pair_sample_trigger;
  logic        external_conversion_clock;
  logic        config_source_pin;
  logic        range_pin;
  logic        cw_load;
  logic [31:0] cw_data;
  logic        busy_int;

  modport device (
    input  pair_sample_trigger,
    input  external_conversion_clock,
    input  config_source_pin,
    input  range_pin,
    input  cw_load,
    input  cw_data,
    output busy_int
  );

  modport host (
    output pair_sample_trigger,
    output external_conversion_clock,
    output config_source_pin,
    output range_pin,
    output cw_load,
    output cw_data,
    input  busy_int
  );
endinterface

// ===== design/pair_converter.sv
// one converter pair: hold, wait for clock edge, count 18.5 cycles
`timescale 1ns/1ps
module pair_converter
  import conv_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic trig_rise,
  input  wire logic trig_level,
  input  wire logic conv_edge,
  output logic      hold,
  output logic      busy,
  output logic      done,
  output logic      power_down
);

  pair_state_e state_reg, state_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        done_reg, done_next;

  // -------------------------------------------------------------------
  // pair sequencing
  // -------------------------------------------------------------------
  // counts conversion clock edges, so a stopped external clock just
  // stalls the pair rather than breaking it
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    case (state_reg)
      PAIR_IDLE, PAIR_DOWN: begin
        if (trig_rise) begin
          state_next = PAIR_WAIT;
        end
      end
      PAIR_WAIT: begin
        if (!trig_level) begin
          state_next = PAIR_DOWN;
        end else if (conv_edge) begin
          state_next = PAIR_CONV;
          cnt_next   = 6'd1;
        end
      end
      PAIR_CONV: begin
        if (!trig_level) begin
          state_next = PAIR_DOWN;
        end else if (conv_edge) begin
          if (cnt_reg == CONV_HALF_W) begin
            state_next = PAIR_IDLE;
            done_next  = 1'b1;
          end else begin
            cnt_next = cnt_reg + 6'd1;
          end
        end
      end
      default: state_next = PAIR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= PAIR_IDLE;
      cnt_reg   <= 6'd0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
    end
  end

  assign hold       = (state_reg == PAIR_WAIT) || (state_reg == PAIR_CONV);
  assign busy       = hold;
  assign done       = done_reg;
  assign power_down = (state_reg == PAIR_DOWN);

endmodule

// ===== tb/conv_link_checker.sv
// concurrent checks on the link between host and converter control
`timescale 1ns/1ps
module conv_link_checker
  import conv_ctrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [2:0]  pair_sample_trigger,
  input wire logic        external_conversion_clock,
  input wire logic        config_source_pin,
  input wire logic        range_pin,
  input wire logic        cw_load,
  input wire logic [31:0] cw_data,
  input wire logic        busy_int
);
  logic       pol_reg;
  logic       pol_next;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic       act;
  logic [2:0] trg;

  assign trg = pair_sample_trigger;
  assign act = busy_int ^ pol_reg;  // busy in true sense

  // mirror of the polarity bit; hardware-mode loads never land
  always_comb begin
    pol_next = pol_reg;
    if (cw_load && config_source_pin) pol_next = cw_data[BUSY_POL_B];
    cnt_next = act ? cnt_reg + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk) begin
    pol_reg <= reset ? 1'b0 : pol_next;
    cnt_reg <= reset ? 10'h000 : cnt_next;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_busy_rise;
    $rose(trg[0]) |=> act;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy did not follow trigger");
  property p_busy_min;
    $rose(act) |-> act [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy dropped right after start");
  // each counted edge needs at least one system clock
  property p_conv_len;
    $fell(act) |-> cnt_reg >= 10'h025;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion shorter than 37 half cycles");
  property p_busy_bound;
    act |-> cnt_reg < 10'h258;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy held too long");
  property p_trig_hold;
    $fell(trg[0]) |-> !$past(act);
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger released while busy");
  property p_idle;
    (trg == 3'h0) && !act |=> !act;
  endproperty
  a_idle: assert property (p_idle)
    else $error("busy rose without trigger");
  property p_pol;
    cw_load && config_source_pin && !act && trg == 3'h0
      |=> busy_int == pol_reg;
  endproperty
  a_pol: assert property (p_pol)
    else $error("idle busy level ignores polarity bit");
  property p_hw_keep;
    cw_load && !config_source_pin && !act && trg == 3'h0
      |=> $stable(busy_int);
  endproperty
  a_hw_keep: assert property (p_hw_keep)
    else $error("hardware-mode load changed busy");

  c_conv:   cover property ($fell(act));
  c_pol_hi: cover property (pol_reg && $rose(act));
  c_multi:  cover property ($rose(act) && trg[1]);
endmodule

// ===== tb/tb_six_channel_sample_conversion_control.sv
// self-checking bench: host and device end joined over the link
`timescale 1ns/1ps
module tb_six_channel_sample_conversion_control;
  import conv_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sw_mode, range_lvl, cfg_write, ext_lvl, act_low;
  logic [31:0] cfg_word, w, ew;
  logic [2:0]  start, hold, pdn, load, rx4, act_p, hs, ls;
  logic        ref3, ref_en, dlow, ext_use, rdy, r, sref, cref, cr;
  logic [9:0]  dac;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t, seed_v;
  logic [31:0] tw [6] = '{32'h0000_03FF, 32'h0000_03FF, 32'h0000_03FF,
                         32'h0010_03FF, 32'h0000_0BFF, 32'h0020_03FF};
  logic [2:0]  tp [6] = '{3'h2, 3'h3, 3'h1, 3'h1, 3'h1, 3'h4};
  logic [2:0]  th [6] = '{3'h2, 3'h3, 3'h7, 3'h7, 3'h7, 3'h4};

  conv_link_if link ();
  conv_device i_conv_device (.clk(clk), .reset(reset), .link(link),
    .pair_hold(hold), .pair_power_down(pdn), .pair_result_load(load),
    .pair_range_x4(rx4), .ref_is_3v(ref3), .ref_enable(ref_en),
    .ref_dac_code(dac), .dac_code_low(dlow), .ext_clock_in_use(ext_use));
  conv_host i_conv_host (.clk(clk), .reset(reset), .link(link),
    .sw_mode(sw_mode), .range_pin_level(range_lvl), .cfg_write(cfg_write),
    .cfg_word(cfg_word), .start_pairs(start), .ext_clock_level(ext_lvl),
    .busy_active_low(act_low), .cfg_refused(cref), .start_refused(sref),
    .results_ready(rdy), .active_pairs(act_p));
  conv_link_checker i_conv_link_checker (.clk(clk), .reset(reset),
    .pair_sample_trigger(link.pair_sample_trigger),
    .external_conversion_clock(link.external_conversion_clock),
    .config_source_pin(link.config_source_pin), .range_pin(link.range_pin),
    .cw_load(link.cw_load), .cw_data(link.cw_data),
    .busy_int(link.busy_int));

  // ------------------------------------------------------------------
  // clock, watchdog and external conversion clock
  // ------------------------------------------------------------------
  always #2 clk = ~clk;
  // 7-cycle half period keeps the external clock under 20 MHz;
  // it is forced low at the next 7-cycle step once no pair is triggered
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 7 == 0) ext_lvl <= (act_p != 3'h0) ? ~ext_lvl : 1'b0;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // tasks and expectations
  // ------------------------------------------------------------------
  function automatic int conv_lo(input logic ext);
    return CONV_HALF * (ext ? 7 : INT_HALF_CYC);
  endfunction
  function automatic int conv_hi(input logic ext);
    return conv_lo(ext) + 2 * (ext ? 7 : INT_HALF_CYC) + 8;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // one control word offer; the sw flag picks the mode pin
  task automatic cfg(input logic sw, input logic [31:0] cw);
    @(posedge clk);
    sw_mode <= sw;
    cfg_word <= cw;
    act_low <= cw[BUSY_POL_B];
    cfg_write <= 1'b1;
    @(posedge clk);
    cfg_write <= 1'b0;
    #1;
    cr = cref;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // start pairs and wait, bounded, for the host to see results
  task automatic run(input logic [2:0] p);
    t = 0;
    hs = 3'h0;
    ls = 3'h0;
    @(posedge clk);
    start <= p;
    @(posedge clk);
    start <= 3'h0;
    while (rdy !== 1'b1 && t < 2000) begin
      @(posedge clk);
      #1;
      t++;
      hs = hs | hold;
      ls = ls | load;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    sw_mode = 1'b0;
    range_lvl = 1'b0;
    cfg_write = 1'b0;
    ext_lvl = 1'b0;
    act_low = 1'b0;
    cfg_word = 32'h0000_0000;
    start = 3'h0;
    ew = CW_RESET;
    seed_v = $urandom(45);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(dac, 32'h0000_03FF);
    chk(ref_en, 32'h0000_0000);
    chk(ext_use, 32'h0000_0000);
    // random words over the coined fields, two corners at the dac floor
    for (int i = 0; i < 20; i++) begin
      w = $urandom() & 32'h03C4_0BFF;
      if (i < 2) w[9:0] = DAC_MIN - 10'(i);
      cfg(1'b1, w);
      chk(cr, w[9:0] < DAC_MIN);
      if (w[9:0] >= DAC_MIN) ew = w;
      chk(dac, ew[9:0]);
      chk(ref3, ew[REF_FS_B]);
      chk(ref_en, ew[REF_EN_B]);
      chk(ext_use, ew[CLK_SRC_B]);
      chk(dlow, ew[9:0] < DAC_MIN);
      chk(rx4, ew[RANGE_LSB +: 3]);
    end
    cfg(1'b0, ~w);
    chk(dac, ew[9:0]);
    chk(ext_use, 32'h0000_0000);
    // conversion table: two hardware cases, then software modes
    for (int k = 0; k < 6; k++) begin
      r = $urandom();
      cfg(1'b1, tw[k]);
      if (k < 2) cfg(1'b0, tw[k]);
      range_lvl <= r;
      run(tp[k]);
      chk(rdy, 32'h0000_0001);
      chk(hs, th[k]);
      chk(ls, th[k]);
      chk(pdn, 32'h0000_0000);
      chk_in(t, conv_lo(tw[k][CLK_SRC_B]), conv_hi(tw[k][CLK_SRC_B]));
      if (k < 2) chk(rx4, {3{r}});
      if (k == 0) begin
        range_lvl <= ~r;
        repeat (4) @(posedge clk);
        #1;
        chk(rx4, {3{r}});
      end
    end
    // retrigger of a busy pair is refused; a mode flip mid-conversion
    // drops the fanned-out triggers of pairs 1 and 2
    cfg(1'b1, tw[2]);
    @(posedge clk);
    start <= 3'h1;
    @(posedge clk);
    start <= 3'h0;
    repeat (4) @(posedge clk);
    start <= 3'h1;
    @(posedge clk);
    start <= 3'h0;
    #1;
    chk(sref, 32'h0000_0001);
    repeat (20) @(posedge clk);
    sw_mode <= 1'b0;
    repeat (300) @(posedge clk);
    #1;
    chk(pdn, 32'h0000_0006);
    end_sim();
  end
endmodule
